// [dv/rtcf_sva.sv]
`timescale 1ns/1ps
module rtcf_sva #(
  parameter int unsigned BUSY_CYC = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_o,
  input wire logic update_in_progress_o
);
  logic [31:0] bcnt;
  logic [31:0] next_bcnt;
  logic rd;
  logic [7:0] wa;
  ////////////////////////////////////////
  // busy length counter, cleared by reset so a cut window is not judged
  always_comb begin
    next_bcnt = update_in_progress_o ? bcnt + 32'h1 : 32'h0;
  end
  always_ff @(posedge clk_i) begin
    bcnt <= rst_i ? 32'h0 : next_bcnt;
  end
  assign rd = wb_ack_o && !wb_we_i;
  assign wa = {wb_adr_i[7:2], 2'h0};
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("request not answered");
  a_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_busy_length: assert property ($fell(update_in_progress_o)
    && !$past(rst_i) |-> bcnt == BUSY_CYC) else $error("busy length");
  a_status_busy: assert property (rd && wa == rtcf_pkg::OFF_STATUS
    |-> wb_dat_o[0] == $past(update_in_progress_o)) else $error("status");
  a_read_upper: assert property (rd |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits");
  a_clear_reads: assert property (rd && wa >= rtcf_pkg::OFF_CLEAR
    |-> wb_dat_o == 32'h0) else $error("clear or unmapped read");
  a_irq_masked: assert property (wb_ack_o && wb_we_i && wb_sel_i[0]
    && wa == rtcf_pkg::OFF_ENABLE && wb_dat_i[7:0] == 8'h00 |-> !irq_o)
    else $error("irq with enables off");
endmodule // rtcf_sva

bind rtcf_core rtcf_sva #(.BUSY_CYC(BUSY_CYC)) u_sva (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq_o(irq_o), .update_in_progress_o(update_in_progress_o));

// [dv/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
  logic clk_i, rst_i, cyc, stb, we, ack, irq, busy;
  logic [7:0] adr, q;
  logic [3:0] sel;
  logic [31:0] dat_w, dat_r;
  int error_cnt, checks;
  // short counts keep one simulated second at 160 cycles
  rtcf_core #(.QUARTER_CYC(40), .BUSY_CYC(10), .FRC_DIV(4)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_w),
    .wb_dat_o(dat_r), .wb_ack_o(ack), .irq_o(irq),
    .update_in_progress_o(busy));
  always #4 clk_i = ~clk_i;
  ////////////////////////////////////////
  task automatic stop_test;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  // one classic cycle; the idle edge at the end keeps cyc low a cycle
  task automatic wb(input logic w, input logic [7:0] a, d,
                    input logic [3:0] s);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    sel <= s;
    dat_w <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = dat_r[7:0];
    if (n >= 50) begin
      chk("ack", 8'h01, 8'h00);
      stop_test();
    end else begin
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk_i);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    wb(1'b1, a, d, 4'h1);
  endtask
  task automatic rd(input string nm, input logic [7:0] a, e);
    wb(1'b0, a, 8'h00, 4'h1);
    chk(nm, e, q);
  endtask
  // bounded wait on the busy level
  task automatic await_busy(input logic v);
    int n;
    n = 0;
    while (busy !== v && n < 400) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 400) begin
      chk("busy", {7'h0, v}, {7'h0, busy});
      stop_test();
    end
  endtask
  ////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    {cyc, stb, we, adr, sel, dat_w} = '0;
    error_cnt = 0;
    checks = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("flags", 8'h00, 8'h00);
    rd("enable", 8'h04, 8'h00);
    rd("status", 8'h0C, 8'h00);
    rd("unmapped", 8'h3C, 8'h00);
    wr(8'h04, 8'hA5);
    rd("enable", 8'h04, 8'hA5);
    wb(1'b1, 8'h04, 8'h00, 4'h0);
    rd("enable", 8'h04, 8'hA5);
    // one second before the week rolls over
    wr(8'h10, 8'h3B);
    wr(8'h14, 8'h3B);
    wr(8'h18, 8'h17);
    wr(8'h1C, 8'h06);
    wr(8'h04, 8'h00);
    wr(8'h08, 8'h01);
    await_busy(1'b1);
    rd("status", 8'h0C, 8'h01);
    await_busy(1'b0);
    wr(8'h08, 8'h00);
    rd("flags", 8'h00, 8'h7F);
    rd("status", 8'h0C, 8'h00);
    // two passes over the time; both must give the same words
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 4; i++) begin
        rd("time", 8'h10 + 8'(4 * i), 8'h00);
      end
    end
    rd("flags", 8'h00, 8'h7F);
    chk("irq", 8'h00, {7'h0, irq});
    wr(8'h00, 8'h5A);
    rd("flags", 8'h00, 8'h5A);
    wr(8'h04, 8'h24);
    chk("irq", 8'h00, {7'h0, irq});
    wr(8'h04, 8'h02);
    chk("irq", 8'h01, {7'h0, irq});
    wr(8'h00, 8'h00);
    rd("flags", 8'h00, 8'h00);
    wr(8'h00, 8'hFF);
    rd("flags", 8'h00, 8'h00);
    rd("clear", 8'h20, 8'h00);
    // time must ride through a reset
    wr(8'h10, 8'h2A);
    rst_i <= 1'b1;
    @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd("seconds", 8'h10, 8'h2A);
    // free counter two counts short of its wrap
    wr(8'h04, 8'h80);
    wr(8'h08, 8'h03);
    wr(8'h10, 8'hFE);
    repeat (12) @(posedge clk_i);
    rd("flags", 8'h00, 8'h80);
    chk("irq", 8'h01, {7'h0, irq});
    wr(8'h04, 8'h00);
    chk("irq", 8'h00, {7'h0, irq});
    // clear register: only the bits written as 1 drop
    wr(8'h20, 8'h7F);
    rd("flags", 8'h00, 8'h80);
    wr(8'h20, 8'h80);
    rd("flags", 8'h00, 8'h00);
    stop_test();
  end
endmodule // tb_top

// [logic/rtcf_core.sv]
// Added by the designer: the register offsets and the Wishbone slave port.
`timescale 1ns/1ps
// Behaviour
// RULE1 - flags stay set after an event; interrupt acceptance never clears them
// RULE2 - writing 0 clears a set flag; writing 1 leaves it unchanged
// RULE3 - bit 7 flag sets when the 8-bit free counter wraps
// RULE4 - bits 6..0: week, day, hour, minute, second, half, quarter flags
// RULE5 - weekly event fires when day-of-week becomes 0
// RULE6 - daily event fires whenever day-of-week advances
// RULE7 - hourly and minute events fire when hour or minute advance
// RULE8 - one-second event fires whenever seconds advance
// RULE9 - periodic events every 0.5 s and every 0.25 s
// RULE10 - eight sources, each with own flag and own enable
// RULE11 - time registers survive every reset; undefined after power-up
// RULE12 - busy rises at update start, time written 62.5 ms later, busy falls; here busy falls one cycle before the time write
// RULE13 - polling software waits for busy falling before reading time
// RULE14 - interrupt software checks flag set and busy low before reading
// RULE15 - software may read time twice and accept only matching passes
// RULE16 - software initialises clock registers before system interrupt enable
// RULE17 - enable register: wrap bit 7 down to quarter bit 0
// RULE18 - free mode disables clock and runs an 8-bit free counter
// RULE19 - irq high while any flag and its enable are both set
module rtcf_core #(
  parameter int unsigned QUARTER_CYC = rtcf_pkg::QUARTER_CYC,
  parameter int unsigned BUSY_CYC = rtcf_pkg::BUSY_CYC,
  parameter int unsigned FRC_DIV = rtcf_pkg::FRC_DIV
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  output logic update_in_progress_o
);
  ////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (BUSY_CYC == 0 || BUSY_CYC >= QUARTER_CYC) begin : g_bad_busy
    $error("busy window must be nonzero and shorter than a quarter");
  end

  ////////////////////////////////////////////////////////////////////////
  // declarations
  logic ack;
  logic next_ack;
  logic [31:0] rdat;
  logic [31:0] next_rdat;
  logic [7:0] clock_event_flags;
  logic [7:0] next_flags;
  logic [7:0] irq_en;
  logic [7:0] next_irq_en;
  logic [1:0] ctrl;
  logic [1:0] next_ctrl;
  logic [1:0] qcnt;
  logic [1:0] next_qcnt;
  logic [5:0] sec;
  logic [5:0] next_sec;
  logic [5:0] min;
  logic [5:0] next_min;
  logic [4:0] hour;
  logic [4:0] next_hour;
  logic [2:0] dow;
  logic [2:0] next_dow;
  logic [7:0] frc;
  logic [7:0] next_frc;
  logic [7:0] ev;
  logic [7:0] clr;
  logic q_tick;
  logic f_tick;
  logic [31:0] q_phase;
  logic busy;
  logic req;
  logic wr;
  logic run;
  logic free_mode;

  // register decode, used by every write and read path
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    hit = (adr[7:2] == off[7:2]);
  endfunction

  assign req = wb_cyc_i & wb_stb_i & ~ack;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign run = ctrl[rtcf_pkg::CTRL_RUN];
  assign free_mode = ctrl[rtcf_pkg::CTRL_FREE];

  ////////////////////////////////////////////////////////////////////////
  // time bases: quarter-second for the clock, prescaler for free mode
  rtcf_tick_gen #(
    .PERIOD(QUARTER_CYC)
  ) u_quarter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(run & ~free_mode), // RULE18
    .tick_o(q_tick),
    .phase_o(q_phase)
  );

  rtcf_tick_gen #(
    .PERIOD(FRC_DIV)
  ) u_prescale (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .en_i(run & free_mode), // RULE18
    .tick_o(f_tick),
    .phase_o()
  );

  // busy covers the last stretch before the second boundary write
  assign busy = run & ~free_mode & (qcnt == rtcf_pkg::QCNT_LAST) &
    (q_phase >= 32'(QUARTER_CYC - BUSY_CYC)); // RULE12

  ////////////////////////////////////////////////////////////////////////
  // calendar chain and event pulses
  always_comb begin
    next_qcnt = qcnt;
    next_sec = sec;
    next_min = min;
    next_hour = hour;
    next_dow = dow;
    next_frc = frc;
    ev = 8'h00;
    if (q_tick) begin
      next_qcnt = qcnt + 2'h1;
      ev[rtcf_pkg::EV_QUARTER] = 1'b1; // RULE9
      ev[rtcf_pkg::EV_HALF] = qcnt[0]; // RULE9
      if (qcnt == rtcf_pkg::QCNT_LAST) begin
        // second boundary: busy already dropped one cycle before the new time lands
        ev[rtcf_pkg::EV_SEC] = 1'b1; // RULE8 RULE12
        if (sec >= rtcf_pkg::SEC_MAX) begin
          next_sec = 6'h00;
          ev[rtcf_pkg::EV_MIN] = 1'b1; // RULE7
          if (min >= rtcf_pkg::MIN_MAX) begin
            next_min = 6'h00;
            ev[rtcf_pkg::EV_HOUR] = 1'b1; // RULE7
            if (hour >= rtcf_pkg::HOUR_MAX) begin
              next_hour = 5'h00;
              ev[rtcf_pkg::EV_DAY] = 1'b1; // RULE6
              if (dow >= rtcf_pkg::DOW_MAX) begin
                next_dow = 3'h0;
                ev[rtcf_pkg::EV_WEEK] = 1'b1; // RULE5
              end else begin
                next_dow = dow + 3'h1;
              end
            end else begin
              next_hour = hour + 5'h01;
            end
          end else begin
            next_min = min + 6'h01;
          end
        end else begin
          next_sec = sec + 6'h01;
        end
      end
    end
    if (f_tick) begin
      next_frc = frc + 8'h01;
      ev[rtcf_pkg::EV_WRAP] = (frc == rtcf_pkg::FRC_MAX); // RULE3
    end
    // software writes set the time; they win over a same-cycle advance
    if (wr && hit(wb_adr_i, rtcf_pkg::OFF_SEC)) begin
      if (free_mode) begin
        next_frc = wb_dat_i[7:0];
      end else begin
        next_sec = wb_dat_i[5:0];
      end
    end
    if (wr && hit(wb_adr_i, rtcf_pkg::OFF_MIN)) begin
      next_min = wb_dat_i[5:0];
    end
    if (wr && hit(wb_adr_i, rtcf_pkg::OFF_HOUR)) begin
      next_hour = wb_dat_i[4:0];
    end
    if (wr && hit(wb_adr_i, rtcf_pkg::OFF_DOW)) begin
      next_dow = wb_dat_i[2:0];
    end
  end

  // time registers carry no reset so they survive any system reset
  always_ff @(posedge clk_i) begin
    sec <= next_sec; // RULE11
    min <= next_min;
    hour <= next_hour;
    dow <= next_dow;
    frc <= next_frc;
  end

  ////////////////////////////////////////////////////////////////////////
  // sticky flags: set wins over a clear in the same cycle
  for (genvar i = 0; i < 8; i++) begin : g_flag
    assign clr[i] =
      (wr && hit(wb_adr_i, rtcf_pkg::OFF_FLAGS) && !wb_dat_i[i] &&
       clock_event_flags[i]) || // RULE2
      (wr && hit(wb_adr_i, rtcf_pkg::OFF_CLEAR) && wb_dat_i[i]);
    assign next_flags[i] =
      ev[i] | (clock_event_flags[i] & ~clr[i]); // RULE1 RULE4 RULE10
  end

  ////////////////////////////////////////////////////////////////////////
  // control registers
  always_comb begin
    next_irq_en = irq_en;
    next_ctrl = ctrl;
    if (wr && hit(wb_adr_i, rtcf_pkg::OFF_ENABLE)) begin
      next_irq_en = wb_dat_i[7:0]; // RULE17
    end
    if (wr && hit(wb_adr_i, rtcf_pkg::OFF_CTRL)) begin
      next_ctrl = wb_dat_i[1:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_event_flags <= rtcf_pkg::FLAGS_RESET;
      irq_en <= rtcf_pkg::ENABLE_RESET;
      ctrl <= rtcf_pkg::CTRL_RESET;
      qcnt <= rtcf_pkg::QCNT_RESET;
    end else begin
      clock_event_flags <= next_flags;
      irq_en <= next_irq_en;
      ctrl <= next_ctrl;
      qcnt <= next_qcnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wishbone read path and acknowledge; unmapped reads return zero
  always_comb begin
    next_ack = req;
    next_rdat = rdat;
    if (req && !wb_we_i) begin
      next_rdat = 32'h00000000;
      if (hit(wb_adr_i, rtcf_pkg::OFF_FLAGS)) begin
        next_rdat[7:0] = clock_event_flags;
      end else if (hit(wb_adr_i, rtcf_pkg::OFF_ENABLE)) begin
        next_rdat[7:0] = irq_en;
      end else if (hit(wb_adr_i, rtcf_pkg::OFF_CTRL)) begin
        next_rdat[1:0] = ctrl;
      end else if (hit(wb_adr_i, rtcf_pkg::OFF_STATUS)) begin
        next_rdat[rtcf_pkg::STATUS_BUSY] = busy; // RULE12
      end else if (hit(wb_adr_i, rtcf_pkg::OFF_SEC)) begin
        next_rdat[7:0] = free_mode ? frc : {2'h0, sec}; // RULE18
      end else if (hit(wb_adr_i, rtcf_pkg::OFF_MIN)) begin
        next_rdat[5:0] = min;
      end else if (hit(wb_adr_i, rtcf_pkg::OFF_HOUR)) begin
        next_rdat[4:0] = hour;
      end else if (hit(wb_adr_i, rtcf_pkg::OFF_DOW)) begin
        next_rdat[2:0] = dow;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'b0;
      rdat <= 32'h00000000;
    end else begin
      ack <= next_ack;
      rdat <= next_rdat;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  assign wb_ack_o = ack;
  assign wb_dat_o = rdat;
  assign irq_o = |(clock_event_flags & irq_en); // RULE19
  assign update_in_progress_o = busy;
endmodule // rtcf_core

// [logic/rtcf_pkg.sv]
package rtcf_pkg;
  // register byte offsets, one aligned 32-bit word each
  localparam logic [7:0] OFF_FLAGS = 8'h00;
  localparam logic [7:0] OFF_ENABLE = 8'h04;
  localparam logic [7:0] OFF_CTRL = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0C;
  localparam logic [7:0] OFF_SEC = 8'h10;
  localparam logic [7:0] OFF_MIN = 8'h14;
  localparam logic [7:0] OFF_HOUR = 8'h18;
  localparam logic [7:0] OFF_DOW = 8'h1C;
  localparam logic [7:0] OFF_CLEAR = 8'h20;

  // event bit positions, shared by flags, enables and clear
  localparam int unsigned EV_WRAP = 7;
  localparam int unsigned EV_WEEK = 6;
  localparam int unsigned EV_DAY = 5;
  localparam int unsigned EV_HOUR = 4;
  localparam int unsigned EV_MIN = 3;
  localparam int unsigned EV_SEC = 2;
  localparam int unsigned EV_HALF = 1;
  localparam int unsigned EV_QUARTER = 0;

  // control and status fields
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_FREE = 1;
  localparam int unsigned STATUS_BUSY = 0;

  // reset values of control state
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [1:0] CTRL_RESET = 2'h0;
  localparam logic [1:0] QCNT_RESET = 2'h0;

  // calendar limits
  localparam logic [5:0] SEC_MAX = 6'h3B;
  localparam logic [5:0] MIN_MAX = 6'h3B;
  localparam logic [4:0] HOUR_MAX = 5'h17;
  localparam logic [2:0] DOW_MAX = 3'h6;
  localparam logic [1:0] QCNT_LAST = 2'h3;
  localparam logic [7:0] FRC_MAX = 8'hFF;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned QUARTER_NS = 250000000;
  localparam int unsigned BUSY_NS = 62500000;
  localparam int unsigned QUARTER_CYC = QUARTER_NS / CLK_PERIOD_NS;
  localparam int unsigned BUSY_CYC = BUSY_NS / CLK_PERIOD_NS;
  localparam int unsigned FRC_DIV = 256;
endpackage

// [logic/rtcf_tick_gen.sv]
`timescale 1ns/1ps
module rtcf_tick_gen #(
  parameter int unsigned PERIOD = 256
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  output logic tick_o,
  output logic [31:0] phase_o
);
  logic [31:0] count;
  logic [31:0] next_count;
  logic next_tick;
  logic tick;

  if (PERIOD < 2) begin : g_bad
    $error("tick period must be at least two cycles");
  end

  // counter holds while disabled so a stop does not lose the phase
  always_comb begin
    next_count = count;
    next_tick = 1'b0;
    if (en_i) begin
      if (count == 32'(PERIOD - 1)) begin
        next_count = 32'h00000000;
        next_tick = 1'b1;
      end else begin
        next_count = count + 32'h00000001;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count <= 32'h00000000;
      tick <= 1'b0;
    end else begin
      count <= next_count;
      tick <= next_tick;
    end
  end

  assign tick_o = tick;
  assign phase_o = count;
endmodule // rtcf_tick_gen
